// ===== rtl/odc_pkg.sv
// odc_pkg: offsets, field positions, reset values, unlock keys and states for the oscillator control block
// assumes a plain register port with word offsets and a single 200 MHz clock
package odc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ODC_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  ODC_OFS_UNLOCK  = 8'h04;
    // ------------------------------------------------------------
    // field positions of oscillator_control
    // ------------------------------------------------------------
    localparam int          ODC_PLL_LSB     = 27;
    localparam int          ODC_FRC_LSB     = 24;
    localparam int          ODC_SOSC_BIT    = 22;
    localparam int          ODC_PBRDY_BIT   = 21;
    localparam int          ODC_PB_LSB      = 19;
    // ------------------------------------------------------------
    // reset values and unlock keys
    // ------------------------------------------------------------
    localparam logic [2:0]  ODC_FRC_RST     = 3'h1;
    // key values are arbitrary
    localparam logic [31:0] ODC_KEY_FIRST   = 32'h1234_5678;
    localparam logic [31:0] ODC_KEY_SECOND  = 32'h8765_4321;
    // ------------------------------------------------------------
    // unlock sequence states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ODC_LOCKED   = 3'b001,
        ODC_KEY_SEEN = 3'b010,
        ODC_OPEN     = 3'b100
    } odc_lock_t;

    // three-bit power-of-two code to shift amount; the top code jumps to 256
    function automatic logic [3:0] odc_code_log(input logic [2:0] code);
        odc_code_log = (code == 3'h7) ? 4'h8 : {1'b0, code};
    endfunction : odc_code_log
endpackage : odc_pkg

// ===== rtl/odc_div_if.sv
// odc_div_if: links the control top to one power-of-two divider
// assumes every signal is synchronous to mclk
`timescale 1ns/10ps
interface odc_div_if;
    logic       tick_in;
    logic [3:0] log2;
    logic       tick_out;
    logic       wrap;
    modport div (input tick_in, input log2, output tick_out, output wrap);
    modport ctl (output tick_in, output log2, input tick_out, input wrap);
endinterface : odc_div_if

// ===== rtl/odc_div.sv
// odc_div: divides a one-cycle tick stream by 2**log2, log2 up to 8
// assumes ticks are single mclk cycles; a log2 change takes effect on the running count
`timescale 1ns/10ps
module odc_div
    import odc_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // divider link
    odc_div_if.div    dv
);
    logic [7:0] cnt;
    logic [7:0] limit;

    assign limit   = 8'(({1'b0, 8'h01} << dv.log2) - 9'h001);
    // compare with >= so a shrinking ratio never strands the count above the limit
    assign dv.wrap = dv.tick_in && (cnt >= limit);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt <= 8'h00;
        end else if (dv.wrap) begin
            cnt <= 8'h00;
        end else if (dv.tick_in) begin
            cnt <= 8'(cnt + 8'h01);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dv.tick_out <= 1'b0;
        end else begin
            dv.tick_out <= dv.wrap;
        end
    end
endmodule : odc_div

// ===== rtl/odc_top.sv
// odc_top: oscillator control register, unlock sequence and clock dividers
// assumes configuration bits are stable during reset and oscillator ticks are mclk-synchronous
`timescale 1ns/10ps
module odc_top
    import odc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // configuration bits
    input  wire logic [2:0]  cfg_pll_output_divider,
    input  wire logic [1:0]  cfg_periph_clock_divisor,
    // oscillator sources
    input  wire logic        pll_tick,
    input  wire logic        fast_rc_tick,
    input  wire logic        secondary_osc_stable,
    // clock enables and the active peripheral divisor
    output logic             pll_clk_en,
    output logic             fast_rc_clk_en,
    output logic             peripheral_bus_clock_en,
    output logic      [1:0]  periph_divisor_active
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [2:0] pll_output_divider;
    logic [2:0] fast_rc_divider;
    logic [1:0] periph_clock_divisor;
    logic       secondary_osc_ready;
    logic       periph_divisor_ready;
    odc_lock_t  lock_state;
    logic       wr_ctrl;
    logic       wr_unlock;
    logic       ctrl_ok;

    odc_div_if pll_if ();
    odc_div_if frc_if ();
    odc_div_if pb_if ();

    assign wr_ctrl   = reg_wr && (reg_addr == ODC_OFS_CTRL);
    assign wr_unlock = reg_wr && (reg_addr == ODC_OFS_UNLOCK);
    assign ctrl_ok   = wr_ctrl && (lock_state == ODC_OPEN);
    // a divisor change is pending until the divider wraps onto it
    assign periph_divisor_ready = (periph_clock_divisor == periph_divisor_active);

    // ------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------
    // any stray write breaks the sequence, so a runaway loop cannot unlock by chance
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lock_state <= ODC_LOCKED;
        end else begin
            case (lock_state)
                ODC_LOCKED: begin
                    if (wr_unlock && reg_wdata == ODC_KEY_FIRST) begin
                        lock_state <= ODC_KEY_SEEN;
                    end
                end
                ODC_KEY_SEEN: begin
                    if (reg_wr) begin
                        lock_state <= (wr_unlock && reg_wdata == ODC_KEY_SECOND) ? ODC_OPEN : ODC_LOCKED;
                    end
                end
                ODC_OPEN: begin
                    if (wr_ctrl) begin
                        lock_state <= ODC_LOCKED;
                    end
                end
                default: begin
                    lock_state <= ODC_LOCKED;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pll_output_divider <= cfg_pll_output_divider;
            fast_rc_divider    <= ODC_FRC_RST;
        end else if (ctrl_ok) begin
            pll_output_divider <= reg_wdata[ODC_PLL_LSB +: 3];
            fast_rc_divider    <= reg_wdata[ODC_FRC_LSB +: 3];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            periph_clock_divisor <= cfg_periph_clock_divisor;
        end else if (ctrl_ok && periph_divisor_ready) begin
            periph_clock_divisor <= reg_wdata[ODC_PB_LSB +: 2];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            periph_divisor_active <= cfg_periph_clock_divisor;
        end else if (pb_if.wrap) begin
            periph_divisor_active <= periph_clock_divisor;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            secondary_osc_ready <= 1'b0;
        end else begin
            secondary_osc_ready <= secondary_osc_stable;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_addr == ODC_OFS_CTRL) begin
                reg_rdata[ODC_PLL_LSB +: 3]  <= pll_output_divider;
                reg_rdata[ODC_FRC_LSB +: 3]  <= fast_rc_divider;
                reg_rdata[ODC_SOSC_BIT]      <= secondary_osc_ready;
                reg_rdata[ODC_PBRDY_BIT]     <= periph_divisor_ready;
                reg_rdata[ODC_PB_LSB +: 2]   <= periph_clock_divisor;
            end else if (reg_addr == ODC_OFS_UNLOCK) begin
                reg_rdata[0] <= (lock_state == ODC_OPEN);
            end
        end
    end

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    assign pll_if.tick_in = pll_tick;
    assign pll_if.log2    = odc_code_log(pll_output_divider);
    assign frc_if.tick_in = fast_rc_tick;
    assign frc_if.log2    = odc_code_log(fast_rc_divider);
    assign pb_if.tick_in  = 1'b1;
    assign pb_if.log2     = {2'b00, periph_divisor_active};

    odc_div u_pll_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .dv      (pll_if)
    );

    odc_div u_frc_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .dv      (frc_if)
    );

    odc_div u_pb_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .dv      (pb_if)
    );

    assign pll_clk_en              = pll_if.tick_out;
    assign fast_rc_clk_en          = frc_if.tick_out;
    assign peripheral_bus_clock_en = pb_if.tick_out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    reserved_bits_zero_a: assert property (
        reg_rd && reg_addr == ODC_OFS_CTRL |=> reg_rdata[31:30] == 2'b00 && reg_rdata[23] == 1'b0)
        else $error("reserved control bits read nonzero");
    locked_write_ignored_a: assert property (
        wr_ctrl && lock_state != ODC_OPEN |=> $stable(pll_output_divider) && $stable(fast_rc_divider))
        else $error("control write accepted while locked");
    relock_after_write_a: assert property (
        wr_ctrl && lock_state == ODC_OPEN |=> lock_state == ODC_LOCKED)
        else $error("lock not restored after control write");
    sosc_read_flag_a: assert property (
        reg_rd && reg_addr == ODC_OFS_CTRL |=> reg_rdata[ODC_SOSC_BIT] == $past(secondary_osc_stable, 2))
        else $error("secondary ready flag does not follow oscillator");
    pb_write_ignored_a: assert property (
        ctrl_ok && !periph_divisor_ready |=> $stable(periph_clock_divisor))
        else $error("divisor changed while not ready");
    pb_ready_drop_a: assert property (
        ctrl_ok && periph_divisor_ready && reg_wdata[ODC_PB_LSB +: 2] != periph_clock_divisor
        |=> !periph_divisor_ready)
        else $error("ready flag stayed high during divisor change");
    pb_ready_bound_a: assert property (
        !periph_divisor_ready |-> ##[1:8] periph_divisor_ready)
        else $error("divisor change never settled");
    pb_rate_eight_a: assert property (
        peripheral_bus_clock_en && periph_divisor_active == 2'b11 && periph_divisor_ready
        |=> !peripheral_bus_clock_en [*7] ##1 peripheral_bus_clock_en)
        else $error("peripheral divide by eight spacing wrong");
    pll_div_one_a: assert property (
        pll_tick && pll_output_divider == 3'h0 && $stable(pll_output_divider) |=> pll_clk_en)
        else $error("pll divide by one missed a tick");
    cfg_load_a: assert property (
        $past(sys_rst) |-> pll_output_divider == $past(cfg_pll_output_divider)
                          && periph_clock_divisor == $past(cfg_periph_clock_divisor))
        else $error("configuration value not loaded at reset");

    unlock_cover_c: cover property (lock_state == ODC_KEY_SEEN ##1 lock_state == ODC_OPEN);
    accepted_write_c: cover property (ctrl_ok);
    pb_change_c: cover property (!periph_divisor_ready ##1 periph_divisor_ready);
    frc_tick_c: cover property (fast_rc_clk_en && fast_rc_divider == 3'h7);
    pb_ignored_c: cover property (ctrl_ok && !periph_divisor_ready);
endmodule : odc_top

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the oscillator control block, register port driven directly
// assumes odc_pkg offsets and keys; tasks are entered just after a rising edge of mclk
`timescale 1ns/10ps
module tb_top;
    import odc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        mclk;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [2:0]  cfg_pll_output_divider;
    logic [1:0]  cfg_periph_clock_divisor;
    logic        pll_tick;
    logic        fast_rc_tick;
    logic        secondary_osc_stable;
    logic        pll_clk_en;
    logic        fast_rc_clk_en;
    logic        peripheral_bus_clock_en;
    logic [1:0]  periph_divisor_active;
    logic [31:0] d;
    int          num_errors;
    int          comparisons;
    wire  [2:0]  ens = {peripheral_bus_clock_en, fast_rc_clk_en, pll_clk_en};

    odc_top odc_top_i (
        .mclk                     (mclk),
        .sys_rst                  (sys_rst),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .cfg_pll_output_divider   (cfg_pll_output_divider),
        .cfg_periph_clock_divisor (cfg_periph_clock_divisor),
        .pll_tick                 (pll_tick),
        .fast_rc_tick             (fast_rc_tick),
        .secondary_osc_stable     (secondary_osc_stable),
        .pll_clk_en               (pll_clk_en),
        .fast_rc_clk_en           (fast_rc_clk_en),
        .peripheral_bus_clock_en  (peripheral_bus_clock_en),
        .periph_divisor_active    (periph_divisor_active)
    );
    // ------------------------------------------------------------
    // clock, pll ticks with gaps so the divider must count ticks, not cycles
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) pll_tick <= sys_rst ? 1'b0 : ~pll_tick;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [31:0] cw(input logic [2:0] p, input logic [2:0] f, input logic s,
                                       input logic r, input logic [1:0] b);
        cw = {2'b00, p, f, 1'b0, s, r, b, 19'h0_0000};
    endfunction : cw
    // strobe stays up after wr so writes can follow back to back; rd drops both
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
        @(posedge mclk);
    endtask : rd
    task automatic unlock();
        wr(ODC_OFS_UNLOCK, ODC_KEY_FIRST);
        wr(ODC_OFS_UNLOCK, ODC_KEY_SECOND);
    endtask : unlock
    task automatic sync(input int s);
        int n;
        n = 0;
        // start on a falling edge so a pulse launched by the edge just passed is seen settled
        @(negedge mclk);
        while (ens[s] !== 1'b1 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 600) begin
            num_errors++;
            $display("ERROR %0t: no enable pulse seen", $time);
        end
    endtask : sync
    task automatic period(input int s, input int e);
        int n;
        sync(s);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (ens[s] !== 1'b1 && n < 600);
        check(n, e);
        @(posedge mclk);
    endtask : period
    task automatic finish_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        num_errors = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cfg_pll_output_divider = 3'h5;
        cfg_periph_clock_divisor = 2'h2;
        fast_rc_tick = 1'b1;
        secondary_osc_stable = 1'b0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(ODC_OFS_CTRL, d);
        check(d, cw(3'h5, ODC_FRC_RST, 1'b0, 1'b1, 2'h2));
        check({30'h0, periph_divisor_active}, 32'h0000_0002);
        // locked write, then a sequence broken by a control write, both ignored
        wr(ODC_OFS_CTRL, 32'hFFFF_FFFF);
        wr(ODC_OFS_UNLOCK, ODC_KEY_FIRST);
        wr(ODC_OFS_CTRL, 32'h0000_0000);
        rd(ODC_OFS_CTRL, d);
        check(d, cw(3'h5, ODC_FRC_RST, 1'b0, 1'b1, 2'h2));
        // a read between the keys keeps the sequence alive
        wr(ODC_OFS_UNLOCK, ODC_KEY_FIRST);
        rd(ODC_OFS_UNLOCK, d);
        check(d, 32'h0000_0000);
        wr(ODC_OFS_UNLOCK, ODC_KEY_SECOND);
        rd(ODC_OFS_UNLOCK, d);
        check(d, 32'h0000_0001);
        rd(8'h08, d);
        check(d, 32'h0000_0000);
        // every code of all three dividers, junk in unimplemented and read-only bits
        for (int n = 0; n < 8; n++) begin
            secondary_osc_stable <= n[0];
            unlock();
            wr(ODC_OFS_CTRL, {2'b11, n[2:0], n[2:0], 1'b1, 2'b11, n[1:0], 19'h7_FFFF});
            rd(ODC_OFS_UNLOCK, d);
            check(d, 32'h0000_0000);
            repeat (20) @(posedge mclk);
            rd(ODC_OFS_CTRL, d);
            check(d, cw(n[2:0], n[2:0], n[0], 1'b1, n[1:0]));
            check({30'h0, periph_divisor_active}, {30'h0, n[1:0]});
            period(0, (n == 7) ? 512 : (2 << n));
            period(1, (n == 7) ? 256 : (1 << n));
            period(2, 1 << n[1:0]);
        end
        // a divisor change right after a wrap: ready drops and the old divisor stays applied;
        // a second change while ready is low loses its divisor field but the other fields land
        unlock();
        reg_wr <= 1'b0;
        sync(2);
        @(posedge mclk);
        wr(ODC_OFS_CTRL, cw(3'h0, 3'h0, 1'b0, 1'b0, 2'h0));
        unlock();
        wr(ODC_OFS_CTRL, cw(3'h2, 3'h2, 1'b0, 1'b0, 2'h2));
        rd(ODC_OFS_CTRL, d);
        check({31'h0, d[ODC_PBRDY_BIT]}, 32'h0000_0000);
        check(d, cw(3'h2, 3'h2, 1'b1, 1'b0, 2'h0));
        check({30'h0, periph_divisor_active}, 32'h0000_0003);
        repeat (12) @(posedge mclk);
        rd(ODC_OFS_CTRL, d);
        check(d, cw(3'h2, 3'h2, 1'b1, 1'b1, 2'h0));
        check({30'h0, periph_divisor_active}, 32'h0000_0000);
        finish_test();
    end
endmodule : tb_top
